/* hw/sbt_params.svh */
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH

// ***************************************************************
// register byte offsets on the axi4-lite bus
// ***************************************************************
`define SBT_OFF_CTRL    8'h00
`define SBT_OFF_MLOW    8'h04
`define SBT_OFF_MHIGH   8'h08
`define SBT_OFF_COUNT   8'h0C
`define SBT_OFF_MVALUE  8'h10
`define SBT_OFF_ISTAT   8'h14
`define SBT_OFF_ICLR    8'h18
`define SBT_OFF_IEN     8'h1C

// ***************************************************************
// control register field positions
// ***************************************************************
`define SBT_CTRL_MODE_BIT 0
`define SBT_CTRL_SRC_LSB  2
`define SBT_CTRL_SRC_MSB  4
`define SBT_CTRL_RUN_BIT  5

// ***************************************************************
// reset values and compare layout
// ***************************************************************
`define SBT_CTRL_RST   8'h00
`define SBT_MATCH_RST  16'hFFFF
`define SBT_COUNT_RST  16'h0000
`define SBT_UPPER_LSB  11

// ***************************************************************
// bus response codes
// ***************************************************************
`define SBT_RESP_OKAY   2'b00
`define SBT_RESP_SLVERR 2'b10

`endif

/* hw/sbt_pkg.sv */
package sbt_pkg;

  // source select codes of the control register
  typedef enum logic [2:0] {
    SRC_DIV_LONG  = 3'b000,
    SRC_DIV_MID   = 3'b001,
    SRC_DIV_SHORT = 3'b010,
    SRC_DIV_FAST  = 3'b011,
    SRC_HF_DIRECT = 3'b100,
    SRC_LF_DIRECT = 3'b101,
    SRC_RESERVED  = 3'b110,
    SRC_EXT_PIN   = 3'b111
  } sbt_src_t;

  // power states reported by the power controller
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_SLOW_ONE_STATE  = 2'b01,
    PWR_SLOW_TWO_STATE  = 2'b10,
    PWR_SLEEP  = 2'b11
  } sbt_pwr_t;

  // control register contents
  typedef struct packed {
    logic     run;
    sbt_src_t src;
    logic     mode;
  } sbt_ctrl_t;

  // divider chain taps, one-cycle enables
  typedef struct packed {
    logic hf_div23;
    logic hf_div13;
    logic hf_div8;
    logic hf_div3;
    logic hf_div0;
    logic lf_div15;
    logic lf_div5;
    logic lf_div0;
  } sbt_ticks_t;

endpackage

/* hw/sbt_prescaler.sv */
`timescale 1ns/1ns

// ***************************************************************
// divider chain for both oscillators
// ***************************************************************
module sbt_prescaler #(
  parameter int HF_W = 23,
  parameter int LF_W = 15
) (
  // clock, reset, clock enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // oscillator enables, one cycle per oscillator period
  input  wire logic              hf_tick,
  input  wire logic              lf_tick,
  // divided taps
  output sbt_pkg::sbt_ticks_t    ticks_q
);

  logic [HF_W-1:0] hf_cnt_q;  // high-frequency divider
  logic [LF_W-1:0] lf_cnt_q;  // low-frequency divider

  // free-running dividers, advance only on their oscillator tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hf_cnt_q <= '0;
      lf_cnt_q <= '0;
    end else if (ce) begin
      if (hf_tick) begin
        hf_cnt_q <= hf_cnt_q + 1'b1;
      end
      if (lf_tick) begin
        lf_cnt_q <= lf_cnt_q + 1'b1;
      end
    end
  end

  // a tap fires when all its lower bits roll over
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ticks_q <= '0;
    end else if (ce) begin
      ticks_q.hf_div23 <= hf_tick & (&hf_cnt_q[22:0]);
      ticks_q.hf_div13 <= hf_tick & (&hf_cnt_q[12:0]);
      ticks_q.hf_div8  <= hf_tick & (&hf_cnt_q[7:0]);
      ticks_q.hf_div3  <= hf_tick & (&hf_cnt_q[2:0]);
      ticks_q.hf_div0  <= hf_tick;
      ticks_q.lf_div15 <= lf_tick & (&lf_cnt_q[14:0]);
      ticks_q.lf_div5  <= lf_tick & (&lf_cnt_q[4:0]);
      ticks_q.lf_div0  <= lf_tick;
    end
  end

endmodule

/* hw/sbt_timer.sv */
`timescale 1ns/1ns
`include "sbt_params.svh"

module sbt_timer #(
  parameter int ADDR_W = 8
) (
  // clock, reset, clock enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // oscillator enables and power state, same clock domain
  input  wire logic              high_freq_osc,
  input  wire logic              low_freq_osc,
  input  wire logic              divider_stage_select,
  input  wire sbt_pkg::sbt_pwr_t power_state,
  input  wire logic              stop_enter,
  // external count / window pin, asynchronous
  input  wire logic              timer2_input_pin,
  // interrupt
  output logic                   timer2_match_irq
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  sbt_pkg::sbt_ctrl_t  ctrl_q;        // timer2_control
  logic [15:0]         match_q;       // timer2_match_value
  logic [7:0]          low_stage_q;   // staged low byte
  logic                low_pend_q;    // low byte written, high pending
  logic [15:0]         count_q;       // up-counter
  logic                stat_q;        // sticky match event
  logic                ien_q;         // interrupt enable
  logic                pin_s1_q;      // synchroniser first stage
  logic                pin_s2_q;      // synchronised level
  logic                pin_s3_q;      // delayed level for edges
  logic                pin_rise;      // rising edge of pin
  sbt_pkg::sbt_ticks_t ticks;         // divider taps
  logic                src_tick;      // selected source enable
  logic                cnt_tick;      // counter advance enable
  logic                upper_only;    // five-bit compare mode
  logic [15:0]         count_inc;     // counter plus one
  logic                hit;           // compare result
  logic                match_evt;     // counter reached match
  // bus side
  logic [ADDR_W-1:0]   awaddr_q;      // held write address
  logic                aw_have_q;     // write address held
  logic [31:0]         wdata_q;       // held write data
  logic [3:0]          wstrb_q;       // held byte enables
  logic                w_have_q;      // write data held
  logic                awready_q;
  logic                wready_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                arready_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic                irq_q;
  logic                wr_fire;       // write performed this cycle
  logic                wr_lane0;      // low byte lane enabled
  logic [7:0]          wr_off;        // write offset
  logic [7:0]          rd_off;        // read offset
  logic [31:0]         rd_data;       // read mux result
  logic                rd_ok;         // read address mapped
  logic                wr_ok;         // write address mapped

  assign awready          = awready_q;
  assign wready           = wready_q;
  assign bvalid           = bvalid_q;
  assign bresp            = bresp_q;
  assign arready          = arready_q;
  assign rvalid           = rvalid_q;
  assign rdata            = rdata_q;
  assign rresp            = rresp_q;
  assign timer2_match_irq = irq_q;

  // ***************************************************************
  // divider chain
  // ***************************************************************
  sbt_prescaler #(
    .HF_W (23),
    .LF_W (15)
  ) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .hf_tick (high_freq_osc),
    .lf_tick (low_freq_osc),
    .ticks_q (ticks)
  );

  // ***************************************************************
  // external pin synchroniser
  // ***************************************************************
  // two flops before use, a third only for the edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else if (ce) begin
      pin_s1_q <= timer2_input_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_rise = pin_s2_q & ~pin_s3_q;

  // ***************************************************************
  // source selection
  // ***************************************************************
  // slow and sleep states leave most codes without a clock
  always_comb begin
    src_tick = 1'b0;
    if (power_state == sbt_pkg::PWR_NORMAL) begin
      unique case (ctrl_q.src)
        sbt_pkg::SRC_DIV_LONG: begin
          src_tick = divider_stage_select ? ticks.lf_div15
                                          : ticks.hf_div23;
        end
        sbt_pkg::SRC_DIV_MID: begin
          src_tick = divider_stage_select ? ticks.lf_div5
                                          : ticks.hf_div13;
        end
        sbt_pkg::SRC_DIV_SHORT: src_tick = ticks.hf_div8;
        sbt_pkg::SRC_DIV_FAST:  src_tick = ticks.hf_div3;
        sbt_pkg::SRC_HF_DIRECT: src_tick = 1'b0;
        sbt_pkg::SRC_LF_DIRECT: src_tick = ticks.lf_div0;
        sbt_pkg::SRC_RESERVED:  src_tick = 1'b0;
        sbt_pkg::SRC_EXT_PIN:   src_tick = pin_rise;
      endcase
    end else begin
      unique case (ctrl_q.src)
        sbt_pkg::SRC_DIV_LONG:  src_tick = ticks.lf_div15;
        sbt_pkg::SRC_DIV_MID:   src_tick = ticks.lf_div5;
        sbt_pkg::SRC_HF_DIRECT: begin
          // direct fast clock only as a slow-2 timer
          src_tick = (power_state == sbt_pkg::PWR_SLOW_TWO_STATE) &&
                     !ctrl_q.mode && ticks.hf_div0;
        end
        sbt_pkg::SRC_EXT_PIN:   src_tick = pin_rise;
        default:                src_tick = 1'b0;
      endcase
    end
  end

  // window mode gates internal clocks with the pin level
  always_comb begin
    if (ctrl_q.mode) begin
      cnt_tick = src_tick && pin_s2_q &&
                 (ctrl_q.src != sbt_pkg::SRC_EXT_PIN);
    end else begin
      cnt_tick = src_tick;
    end
  end

  // ***************************************************************
  // counter and compare
  // ***************************************************************
  assign upper_only = (power_state == sbt_pkg::PWR_SLOW_TWO_STATE) &&
                      (ctrl_q.src == sbt_pkg::SRC_HF_DIRECT);
  assign count_inc  = count_q + 16'h0001;

  // compare the value the counter is about to take
  always_comb begin
    if (upper_only) begin
      hit = count_inc[15:`SBT_UPPER_LSB] ==
            match_q[15:`SBT_UPPER_LSB];
    end else begin
      hit = count_inc == match_q;
    end
  end

  assign match_evt = ctrl_q.run && cnt_tick && hit;

  // counter clears while stopped, wraps to zero on a hit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= `SBT_COUNT_RST;
    end else if (ce) begin
      if (!ctrl_q.run) begin
        count_q <= `SBT_COUNT_RST;
      end else if (cnt_tick) begin
        if (hit) begin
          count_q <= `SBT_COUNT_RST;
        end else begin
          count_q <= count_inc;
        end
      end
    end
  end

  // ***************************************************************
  // write channel handshake
  // ***************************************************************
  assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  assign wr_lane0 = wstrb_q[0];
  assign wr_off   = awaddr_q[7:0];

  // address and data are taken in either order, then held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q  <= '0;
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      w_have_q  <= 1'b0;
      wready_q  <= 1'b1;
    end else if (ce) begin
      if (awvalid && awready_q) begin
        awaddr_q  <= awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end else if (bvalid_q && bready) begin
        aw_have_q <= 1'b0;
        awready_q <= 1'b1;
      end
      if (wvalid && wready_q) begin
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end else if (bvalid_q && bready) begin
        w_have_q <= 1'b0;
        wready_q <= 1'b1;
      end
    end
  end

  // unmapped or read-only offsets answer with a slave error
  always_comb begin
    unique case (wr_off)
      `SBT_OFF_CTRL, `SBT_OFF_MLOW, `SBT_OFF_MHIGH,
      `SBT_OFF_ICLR, `SBT_OFF_IEN: wr_ok = 1'b1;
      default:                     wr_ok = 1'b0;
    endcase
  end

  // response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SBT_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? `SBT_RESP_OKAY : `SBT_RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // control register
  // ***************************************************************
  // stop entry beats a same-cycle software start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= sbt_pkg::sbt_ctrl_t'(`SBT_CTRL_RST);
    end else if (ce) begin
      if (wr_fire && wr_lane0 && wr_off == `SBT_OFF_CTRL) begin
        ctrl_q.src  <= sbt_pkg::sbt_src_t'(
          wdata_q[`SBT_CTRL_SRC_MSB:`SBT_CTRL_SRC_LSB]);
        ctrl_q.mode <= wdata_q[`SBT_CTRL_MODE_BIT];
        ctrl_q.run  <= wdata_q[`SBT_CTRL_RUN_BIT];
      end
      if (stop_enter) begin
        ctrl_q.run <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // match register, low then high
  // ***************************************************************
  // low byte only stages; old value stays in the compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_q     <= `SBT_MATCH_RST;
      low_stage_q <= '0;
      low_pend_q  <= 1'b0;
    end else if (ce) begin
      if (wr_fire && wr_lane0 && wr_off == `SBT_OFF_MLOW) begin
        low_stage_q <= wdata_q[7:0];
        low_pend_q  <= 1'b1;
      end else if (wr_fire && wr_lane0 &&
                   wr_off == `SBT_OFF_MHIGH) begin
        if (low_pend_q) begin
          match_q    <= {wdata_q[7:0], low_stage_q};
          low_pend_q <= 1'b0;
        end else if (upper_only) begin
          // low bits unused here, high byte alone suffices
          match_q[15:8] <= wdata_q[7:0];
        end
      end
    end
  end

  // ***************************************************************
  // interrupt status, enable and output
  // ***************************************************************
  // a new event wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 1'b0;
      ien_q  <= 1'b0;
    end else if (ce) begin
      if (match_evt) begin
        stat_q <= 1'b1;
      end else if (wr_fire && wr_lane0 &&
                   wr_off == `SBT_OFF_ICLR && wdata_q[0]) begin
        stat_q <= 1'b0;
      end
      if (wr_fire && wr_lane0 && wr_off == `SBT_OFF_IEN) begin
        ien_q <= wdata_q[0];
      end
    end
  end

  // level output, high while enabled status is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= stat_q && ien_q;
    end
  end

  // ***************************************************************
  // read channel
  // ***************************************************************
  assign rd_off = araddr[7:0];

  // unstable control bits return zero here
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (rd_off)
      `SBT_OFF_CTRL: begin
        rd_data[`SBT_CTRL_RUN_BIT]                    = ctrl_q.run;
        rd_data[`SBT_CTRL_SRC_MSB:`SBT_CTRL_SRC_LSB]  = ctrl_q.src;
        rd_data[`SBT_CTRL_MODE_BIT]                   = ctrl_q.mode;
      end
      `SBT_OFF_MLOW:   rd_data[7:0]  = low_stage_q;
      `SBT_OFF_MHIGH:  rd_data[7:0]  = match_q[15:8];
      `SBT_OFF_COUNT:  rd_data[15:0] = count_q;
      `SBT_OFF_MVALUE: rd_data[15:0] = match_q;
      `SBT_OFF_ISTAT:  rd_data[0]    = stat_q;
      `SBT_OFF_ICLR:   rd_data       = 32'h0000_0000;
      `SBT_OFF_IEN:    rd_data[0]    = ien_q;
      default:         rd_ok         = 1'b0;
    endcase
  end

  // one read in flight; data registered at address accept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `SBT_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_data;
        rresp_q   <= rd_ok ? `SBT_RESP_OKAY : `SBT_RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

endmodule

/* verif/sbt_timer_bench.sv */
`timescale 1ns/1ns
`include "sbt_params.svh"

module sbt_timer_bench;
  // ***************************************************************
  // stimulus signals
  // ***************************************************************
  logic              aclk = 0;
  logic              aresetn, ce, awvalid, wvalid, bready;
  logic              arvalid, rready, hf_osc, lf_osc, div_sel;
  logic              stop_in, pin, irq, awready, wready;
  logic              bvalid, arready, rvalid;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [3:0]        wstrb;
  sbt_pkg::sbt_pwr_t pwr;
  int                n_fail = 0, checks_done = 0, cyc = 0;
  // error response, for refused accesses
  localparam logic [1:0] ERR = `SBT_RESP_SLVERR;
  // source codes that must not count: normal, normal, slow_one_state, slow_one_state
  localparam logic [2:0] NOCNT [4] = '{3'b100, 3'b110, 3'b100, 3'b101};

  // 25 mhz clock
  always #20 aclk = ~aclk;

  sbt_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .high_freq_osc(hf_osc), .low_freq_osc(lf_osc),
    .divider_stage_select(div_sel), .power_state(pwr),
    .stop_enter(stop_in), .timer2_input_pin(pin),
    .timer2_match_irq(irq)
  );

  // ***************************************************************
  // checking and bus tasks
  // ***************************************************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // write: both channels offered together, bready late on purpose
  task wr(input logic [7:0] a, input logic [31:0] d,
          input logic [1:0] er = 2'b00);
    logic ka;
    logic kw;
    ka = 0;
    kw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ka && kw)) begin
      @(posedge aclk);
      if (!ka && awready) begin
        ka = 1;
        awvalid <= 0;
      end
      if (!kw && wready) begin
        kw = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1;
    @(posedge aclk);
    chk(32'(bresp), 32'(er));
    bready <= 0;
  endtask

  // read: rready late so rdata has to stand
  task rd(input logic [7:0] a, input logic [31:0] e,
          input logic [1:0] er = 2'b00);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1;
    @(posedge aclk);
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    rready <= 0;
  endtask

  // control word: run, source, mode
  function automatic logic [31:0] cv(logic r, logic [2:0] s, logic m);
    return {26'h0, r, s, 1'b0, m};
  endfunction

  // stop, select while stopped, then start
  task go(input logic [2:0] s, input logic m);
    wr(`SBT_OFF_CTRL, 32'h0);
    wr(`SBT_OFF_CTRL, cv(0, s, m));
    wr(`SBT_OFF_CTRL, cv(1, s, m));
  endtask

  // n single-cycle oscillator enables, fast or slow
  task tk(input int n, input logic h);
    repeat (n) begin
      @(posedge aclk);
      hf_osc <= h;
      lf_osc <= !h;
      @(posedge aclk);
      hf_osc <= 0;
      lf_osc <= 0;
      repeat (3) @(posedge aclk);
    end
  endtask

  // n slow rising edges on the pin, wide enough for the synchroniser
  task pe(input int n);
    repeat (n) begin
      repeat (4) @(posedge aclk);
      pin <= 1;
      repeat (4) @(posedge aclk);
      pin <= 0;
    end
    repeat (5) @(posedge aclk);
  endtask

  task end_of_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {hf_osc, lf_osc, div_sel, stop_in, pin} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    ce = 1;
    wstrb = 4'hF;
    pwr = sbt_pkg::PWR_NORMAL;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(`SBT_OFF_CTRL, 32'h0);
    rd(`SBT_OFF_MVALUE, 32'h0000_FFFF);
    rd(`SBT_OFF_COUNT, 32'h0);
    rd(8'h20, 32'h0, ERR);
    wr(`SBT_OFF_COUNT, 32'h5, ERR);
    // unstable bits read as zero, mode bit kept
    wr(`SBT_OFF_CTRL, 32'h0000_00C3);
    rd(`SBT_OFF_CTRL, 32'h1);
    // match loads low then high; old value compared meanwhile
    wr(`SBT_OFF_MLOW, 32'h3);
    rd(`SBT_OFF_MVALUE, 32'h0000_FFFF);
    wr(`SBT_OFF_MHIGH, 32'h0);
    rd(`SBT_OFF_MVALUE, 32'h3);
    wr(`SBT_OFF_MHIGH, 32'h12);
    rd(`SBT_OFF_MVALUE, 32'h3);
    // timer on slow osc, period of three ticks
    wr(`SBT_OFF_IEN, 32'h1);
    go(3'b101, 0);
    tk(2, 0);
    rd(`SBT_OFF_COUNT, 32'h2);
    chk(32'(irq), 32'h0);
    tk(1, 0);
    rd(`SBT_OFF_COUNT, 32'h0);
    chk(32'(irq), 32'h1);
    rd(`SBT_OFF_ISTAT, 32'h1);
    wr(`SBT_OFF_ICLR, 32'h1);
    rd(`SBT_OFF_ISTAT, 32'h0);
    chk(32'(irq), 32'h0);
    // masked event still sets status
    wr(`SBT_OFF_IEN, 32'h0);
    tk(3, 0);
    rd(`SBT_OFF_ISTAT, 32'h1);
    chk(32'(irq), 32'h0);
    wr(`SBT_OFF_ICLR, 32'h1);
    wr(`SBT_OFF_IEN, 32'h1);
    // ticks while the clock enable is low are lost
    ce <= 0;
    tk(1, 0);
    ce <= 1;
    // stopping clears and holds the counter
    tk(1, 0);
    rd(`SBT_OFF_COUNT, 32'h1);
    wr(`SBT_OFF_CTRL, cv(0, 3'b101, 0));
    rd(`SBT_OFF_COUNT, 32'h0);
    tk(1, 0);
    rd(`SBT_OFF_COUNT, 32'h0);
    // stop power state drops the run bit
    go(3'b101, 0);
    @(posedge aclk);
    stop_in <= 1;
    @(posedge aclk);
    stop_in <= 0;
    rd(`SBT_OFF_CTRL, cv(0, 3'b101, 0));
    // pin source counts synchronised rising edges
    go(3'b111, 0);
    pe(2);
    rd(`SBT_OFF_COUNT, 32'h2);
    // sources that offer no clock in the given power state
    for (int i = 0; i < 4; i++) begin
      pwr <= i > 1 ? sbt_pkg::PWR_SLOW_ONE_STATE : sbt_pkg::PWR_NORMAL;
      go(NOCNT[i], 0);
      tk(2, 0);
      tk(2, 1);
      rd(`SBT_OFF_COUNT, 32'h0);
    end
    // slow_two_state direct fast clock, upper byte alone loads
    pwr <= sbt_pkg::PWR_SLOW_TWO_STATE;
    go(3'b100, 0);
    wr(`SBT_OFF_MHIGH, 32'h10);
    tk(2, 1);
    rd(`SBT_OFF_COUNT, 32'h2);
    wr(`SBT_OFF_CTRL, cv(0, 3'b100, 0));
    rd(`SBT_OFF_MVALUE, 32'h1003);
    // window mode counts only while the pin is high
    pwr <= sbt_pkg::PWR_NORMAL;
    go(3'b101, 1);
    tk(2, 0);
    rd(`SBT_OFF_COUNT, 32'h0);
    pin <= 1;
    repeat (4) @(posedge aclk);
    tk(2, 0);
    rd(`SBT_OFF_COUNT, 32'h2);
    pin <= 0;
    end_of_test();
  end
endmodule

/* verif/sbt_timer_checker.sv */
`timescale 1ns/1ns
`include "sbt_params.svh"

// ***************************************************************
// bus handshake and interrupt checks
// ***************************************************************
module sbt_timer_checker #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  // write side
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  // read side
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  // interrupt
  input wire logic              timer2_match_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // address and data taken at one edge
  logic wboth;
  assign wboth = awvalid && awready && wvalid && wready && ce;

  property p_b_stand;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("bresp dropped");
  property p_r_stand;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("rdata dropped");
  property p_w_busy;
    bvalid |-> !awready && !wready;
  endproperty
  a_w_busy: assert property (p_w_busy) else $error("write not blocked");
  property p_b_end;
    bvalid && bready && ce |=> !bvalid && awready && wready;
  endproperty
  a_b_end: assert property (p_b_end) else $error("write not freed");
  property p_r_lat;
    arvalid && arready && ce |=> rvalid && !arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  // unmapped reads answer an error with zero data
  property p_r_bad;
    arvalid && arready && ce && araddr > `SBT_OFF_IEN
      |=> rresp == `SBT_RESP_SLVERR && rdata == 32'h0;
  endproperty
  a_r_bad: assert property (p_r_bad)
    else $error("bad read accepted");
  // read-only count and status places refuse writes
  property p_w_ro;
    wboth && (awaddr == `SBT_OFF_COUNT || awaddr == `SBT_OFF_ISTAT)
      |-> ##2 bvalid && bresp == `SBT_RESP_SLVERR;
  endproperty
  a_w_ro: assert property (p_w_ro)
    else $error("ro write accepted");
  property p_w_ok;
    wboth && awaddr == `SBT_OFF_CTRL
      |-> !bvalid ##1 !bvalid ##1 bvalid && bresp == `SBT_RESP_OKAY;
  endproperty
  a_w_ok: assert property (p_w_ok)
    else $error("control write refused");
  // interrupt only drops after a clear or enable write
  property p_irq_fall;
    $fell(timer2_match_irq) |-> bvalid || $past(bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell alone");
endmodule

bind sbt_timer sbt_timer_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .timer2_match_irq(timer2_match_irq)
);
